// File: rtl/irq_consts.svh
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// machine cycle of four clocks, phase index 0..3
`define CLKS_PER_MC 4
`define PHASE_POLL 2'h0
`define PHASE_THREE 2'h2
`define PHASE_LAST 2'h3
`define CALL_MCS 4
`define CALL_CLKS (`CALL_MCS * `CLKS_PER_MC)
`define CNT_W 5

// request sources, index 0 wins ties
`define NUM_SRC 13
`define SRC_PFAIL 4'h0
`define SRC_EXT0 4'h1
`define SRC_TMR0 4'h2
`define SRC_EXT1 4'h3
`define SRC_TMR1 4'h4
`define SRC_UART0 4'h5
`define SRC_TMR2 4'h6
`define SRC_UART1 4'h7
`define SRC_EXT2 4'h8
`define SRC_EXT3 4'h9
`define SRC_EXT4 4'hA
`define SRC_EXT5 4'hB
`define SRC_WDOG 4'hC

// vector addresses
`define VEC_EXT0 16'h0003
`define VEC_TMR0 16'h000B
`define VEC_EXT1 16'h0013
`define VEC_TMR1 16'h001B
`define VEC_UART0 16'h0023
`define VEC_TMR2 16'h002B
`define VEC_PFAIL 16'h0033
`define VEC_UART1 16'h003B
`define VEC_EXT2 16'h0043
`define VEC_EXT3 16'h004B
`define VEC_EXT4 16'h0053
`define VEC_EXT5 16'h005B
`define VEC_WDOG 16'h0063

// register byte offsets
`define OFS_ENABLE 8'h00
`define OFS_PRIO 8'h04
`define OFS_XENABLE 8'h08
`define OFS_XPRIO 8'h0C
`define OFS_TRIG 8'h10
`define OFS_FLAGS 8'h14
`define OFS_STATUS 8'h18

// field positions and reset values
`define GATE_BIT 7
`define FLAG_TMR0 6
`define FLAG_TMR1 7
`define RST_BYTE 8'h00
`define RST_PINS 6'h3F

`endif

// File: rtl/irq_pkg.sv
`include "irq_consts.svh"

package irq_pkg;

	typedef logic [3:0] src_idx_t;
	typedef logic [`NUM_SRC-1:0] src_vec_t;
	typedef enum logic [0:0] {
		CALL_IDLE = 1'b0,
		CALL_RUN = 1'b1
	} call_state_t;

	// fixed entry address of each source
	function automatic logic [15:0] vector_of(input src_idx_t idx);
		case (idx)
			`SRC_PFAIL: vector_of = `VEC_PFAIL;
			`SRC_EXT0: vector_of = `VEC_EXT0;
			`SRC_TMR0: vector_of = `VEC_TMR0;
			`SRC_EXT1: vector_of = `VEC_EXT1;
			`SRC_TMR1: vector_of = `VEC_TMR1;
			`SRC_UART0: vector_of = `VEC_UART0;
			`SRC_TMR2: vector_of = `VEC_TMR2;
			`SRC_UART1: vector_of = `VEC_UART1;
			`SRC_EXT2: vector_of = `VEC_EXT2;
			`SRC_EXT3: vector_of = `VEC_EXT3;
			`SRC_EXT4: vector_of = `VEC_EXT4;
			`SRC_EXT5: vector_of = `VEC_EXT5;
			default: vector_of = `VEC_WDOG;
		endcase
	endfunction : vector_of

endpackage : irq_pkg

// File: rtl/irq_pick_if.sv
`timescale 1ns/10ps

// requests toward the resolver and its verdict back
interface irq_pick_if;
	import irq_pkg::*;
	src_vec_t req;
	src_vec_t hiSel;
	src_idx_t winIdx;
	logic winValid;
	logic winHi;
	modport pick(input req, input hiSel, output winIdx, output winValid,
		output winHi);
	modport ctrl(output req, output hiSel, input winIdx, input winValid,
		input winHi);
endinterface : irq_pick_if

// File: rtl/irq_pick.sv
`timescale 1ns/10ps
`include "irq_consts.svh"

module irq_pick (
	irq_pick_if.pick sel // requests in, winner out
);
	import irq_pkg::*;

	src_vec_t hiReq;
	src_vec_t hiPre;
	src_vec_t loPre;
	src_vec_t hiOne;
	src_vec_t loOne;
	src_vec_t oneHot;

	assign hiReq = sel.req & sel.hiSel;

	// prefix chains: a bit is first when nothing of lower index asks
	genvar i;
	generate
		for (i = 0; i < `NUM_SRC; i++) begin : g_src
			if (i == 0) begin : g_first
				assign hiPre[i] = 1'b0;
				assign loPre[i] = 1'b0;
			end else begin : g_rest
				assign hiPre[i] = hiPre[i-1] | hiReq[i-1];
				assign loPre[i] = loPre[i-1] | sel.req[i-1];
			end
			assign hiOne[i] = hiReq[i] & ~hiPre[i];
			assign loOne[i] = sel.req[i] & ~loPre[i];
		end
	endgenerate

	// any high request beats every low one
	assign sel.winHi = |hiReq;
	assign sel.winValid = |sel.req;
	assign oneHot = sel.winHi ? hiOne : loOne;

	// one-hot to index
	always_comb begin
		sel.winIdx = '0;
		for (int k = 0; k < `NUM_SRC; k++) begin
			if (oneHot[k]) begin
				sel.winIdx = src_idx_t'(k);
			end
		end
	end

endmodule : irq_pick

// File: rtl/mc_timing.sv
`timescale 1ns/10ps
`include "irq_consts.svh"

module mc_timing #(
	parameter int PINS = 6
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset
	input wire logic [PINS-1:0] pinRaw, // asynchronous pins
	output logic [1:0] phase, // clock index within machine cycle
	output logic [PINS-1:0] pinSync // pins after two flops
);
	logic [PINS-1:0] pinMeta_q;

	// free running phase counter, four clocks per machine cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			phase <= `PHASE_POLL;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	// idle pins are high, so the chain resets high
	always_ff @(posedge clk) begin
		if (rst) begin
			pinMeta_q <= `RST_PINS;
			pinSync <= `RST_PINS;
		end else begin
			pinMeta_q <= pinRaw;
			pinSync <= pinMeta_q;
		end
	end

endmodule : mc_timing

// File: rtl/two_level_priority_interrupt_unit.sv
`timescale 1ns/10ps
`include "irq_consts.svh"

// Summary of operation
// - each source but power fail picks high or low level; low never preempts high
// - equal level ties go by fixed order, power fail first, watchdog last
// - flags are sampled and resolved within each machine cycle
// - no call while equal or higher level is in service
// - call only in the final machine cycle the core signals
// - no call while an enable or priority write or interrupt return is running
// - requests are never remembered; each poll starts afresh
// - vectoring to timer 0 or 1 clears its overflow flag
// - vectoring clears external 0 or 1 flag only in edge mode
// - serial, timer 2, watchdog, power fail flags stay set on vectoring
// - the call pushes the PC like a long call, status word unsaved
// - vectors 0003h, 000Bh, 0013h, 001Bh, 0023h, 002Bh
// - vectors 003Bh, 0043h, 004Bh, 0053h, 005Bh, 0063h
// - interrupt return ends service; plain return leaves it unchanged
// - external pins sampled at phase three, flags set or reset then
// - timer overflow flags set at phase three, polled next cycle
// - the call takes four machine cycles, five from flag to routine
// - single level response is at most 12 machine cycles, 48 clocks
// - individual enables; global gate masks all but power fail
// - timer 2 and serial requests are ORs of their two flags
module two_level_priority_interrupt_unit (
	input wire logic clk, // system clock, 20 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // bus strobe
	input wire logic wb_we_i, // bus write
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic wb_ack_o, // bus acknowledge
	output logic [31:0] wb_dat_o, // read data
	input wire logic [5:0] extIrqPinN, // external request pins, low
	input wire logic timer0OverflowSet, // timer 0 overflow pulse
	input wire logic timer1OverflowSet, // timer 1 overflow pulse
	input wire logic timer2OverflowFlag, // timer 2 overflow flag
	input wire logic timer2ExternalFlag, // timer 2 capture flag
	input wire logic uart0ReceiveDone, // serial 0 receive flag
	input wire logic uart0TransmitDone, // serial 0 transmit flag
	input wire logic uart1ReceiveDone, // serial 1 receive flag
	input wire logic uart1TransmitDone, // serial 1 transmit flag
	input wire logic wdogTimeoutFlag, // watchdog flag
	input wire logic powerFailFlag, // power fail flag
	input wire logic instrLast, // final machine cycle of instruction
	input wire logic coreCfgWrite, // instruction writes enable/prio
	input wire logic isrExitInstr, // instruction is interrupt return
	output logic vecCall, // one clock: start hardware call
	output logic [15:0] vecAddr, // entry address of the call
	output logic callBusy, // call in progress
	output logic inSvcHi, // high level routine active
	output logic inSvcLo // low level routine active
);
	import irq_pkg::*;

	logic [1:0] phase;
	logic [5:0] pinSync;
	logic ack_q;
	logic [7:0] enable_q;
	logic [6:0] prio_q;
	logic [4:0] xEnable_q;
	logic [4:0] xPrio_q;
	logic [1:0] trig_q;
	logic [7:0] flag_q;
	logic [7:0] flag_d;
	logic [5:0] pinPrev_q;
	logic [1:0] ovfPend_q;
	logic cfgSeen_q;
	src_vec_t snap_q;
	call_state_t state_q;
	call_state_t state_d;
	logic [`CNT_W-1:0] cnt_q;
	logic [`CNT_W-1:0] cnt_d;

	irq_pick_if pickBus ();

	mc_timing #(
		.PINS(6)
	) u_timing (
		.clk(clk),
		.rst(rst),
		.pinRaw(extIrqPinN),
		.phase(phase),
		.pinSync(pinSync)
	);

	irq_pick u_pick (
		.sel(pickBus)
	);

	// bus decode; a write lands on the edge where ack is seen
	wire wbReq = wb_cyc_i & wb_stb_i;
	wire wbWr = wbReq & wb_we_i & ack_q & wb_sel_i[0];
	wire [7:0] wdat = wb_dat_i[7:0];
	wire selEn = wb_adr_i == `OFS_ENABLE;
	wire selPri = wb_adr_i == `OFS_PRIO;
	wire selXen = wb_adr_i == `OFS_XENABLE;
	wire selXpri = wb_adr_i == `OFS_XPRIO;
	wire selTrig = wb_adr_i == `OFS_TRIG;
	wire selFlag = wb_adr_i == `OFS_FLAGS;
	wire selStat = wb_adr_i == `OFS_STATUS;
	wire flagWr = wbWr & selFlag;
	wire cfgWr = wbWr & (selEn | selPri | selXen | selXpri);

	// read mux; unmapped offsets read zero
	wire [7:0] statusByte = {5'h00, callBusy, inSvcHi, inSvcLo};
	wire [7:0] rdByte =
		selEn ? enable_q :
		selPri ? {1'b0, prio_q} :
		selXen ? {3'h0, xEnable_q} :
		selXpri ? {3'h0, xPrio_q} :
		selTrig ? {6'h00, trig_q} :
		selFlag ? flag_q :
		selStat ? statusByte : 8'h00;

	// machine cycle moments
	wire pollStart = phase == `PHASE_POLL;
	wire samplePins = phase == `PHASE_THREE;
	wire pollEdge = phase == `PHASE_LAST;

	// source flags in resolution order, index 0 is power fail
	wire gate = enable_q[`GATE_BIT];
	src_vec_t srcFlag;
	src_vec_t srcEn;
	assign srcFlag = {wdogTimeoutFlag, flag_q[5:2],
		uart1ReceiveDone | uart1TransmitDone,
		timer2OverflowFlag | timer2ExternalFlag,
		uart0ReceiveDone | uart0TransmitDone,
		flag_q[`FLAG_TMR1], flag_q[1], flag_q[`FLAG_TMR0], flag_q[0],
		powerFailFlag};
	// power fail escapes the global gate and always ranks high
	assign srcEn = {({xEnable_q, enable_q[6:0]} & {12{gate}}), 1'b1};
	assign pickBus.req = snap_q;
	assign pickBus.hiSel = {xPrio_q, prio_q, 1'b1};

	// the three permission tests for a call
	wire levelOk = pickBus.winHi ? ~inSvcHi : ~(inSvcHi | inSvcLo);
	wire suppress = cfgSeen_q | cfgWr | coreCfgWrite | isrExitInstr;
	wire idle = state_q == CALL_IDLE;
	// worst single-level latency follows from these gates alone
	wire fire = pollEdge & instrLast & pickBus.winValid & levelOk &
		~suppress & idle;
	wire exitNow = pollEdge & instrLast & isrExitInstr;
	wire winEdge = pickBus.winIdx == `SRC_EXT0 ? trig_q[0] :
		pickBus.winIdx == `SRC_EXT1 ? trig_q[1] : 1'b0;

	// only the timer 0/1 flags and edge-mode ext 0/1 flags are cleared;
	// every other source keeps its flag for software
	wire [7:0] vecClr = {
		fire & (pickBus.winIdx == `SRC_TMR1),
		fire & (pickBus.winIdx == `SRC_TMR0),
		4'h0,
		fire & winEdge & (pickBus.winIdx == `SRC_EXT1),
		fire & winEdge & (pickBus.winIdx == `SRC_EXT0)};

	// falling edge seen between two phase three samples
	wire [5:0] edgeSet = pinPrev_q & ~pinSync & {4'hF, trig_q};

	// flag next value: software write, vector clear, then hardware set
	always_comb begin
		flag_d = flagWr ? wdat : flag_q;
		flag_d = flag_d & ~vecClr;
		if (samplePins) begin
			flag_d[5:0] = flag_d[5:0] | edgeSet;
			if (~trig_q[0]) begin
				flag_d[0] = ~pinSync[0];
			end
			if (~trig_q[1]) begin
				flag_d[1] = ~pinSync[1];
			end
			flag_d[`FLAG_TMR0] = flag_d[`FLAG_TMR0] |
				ovfPend_q[0] | timer0OverflowSet;
			flag_d[`FLAG_TMR1] = flag_d[`FLAG_TMR1] |
				ovfPend_q[1] | timer1OverflowSet;
		end
	end

	// call sequencer: four machine cycles of stall for the core
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			CALL_IDLE: begin
				if (fire) begin
					state_d = CALL_RUN;
					cnt_d = `CNT_W'(`CALL_CLKS - 1);
				end
			end
			CALL_RUN: begin
				if (cnt_q == '0) begin
					state_d = CALL_IDLE;
				end else begin
					cnt_d = cnt_q - `CNT_W'(1);
				end
			end
			default: begin
				state_d = CALL_IDLE;
				cnt_d = '0;
			end
		endcase
	end

	// bus slave: ack one clock after the request, dropped next clock
	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			ack_q <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wbReq & ~ack_q;
			ack_q <= wbReq & ~ack_q;
			if (wbReq & ~ack_q) begin
				wb_dat_o <= {24'h000000, rdByte};
			end
		end
	end

	// software configuration registers
	always_ff @(posedge clk) begin
		if (rst) begin
			enable_q <= `RST_BYTE;
			prio_q <= 7'h00;
			xEnable_q <= 5'h00;
			xPrio_q <= 5'h00;
			trig_q <= 2'h0;
		end else if (wbWr) begin
			enable_q <= selEn ? wdat : enable_q;
			prio_q <= selPri ? wdat[6:0] : prio_q;
			xEnable_q <= selXen ? wdat[4:0] : xEnable_q;
			xPrio_q <= selXpri ? wdat[4:0] : xPrio_q;
			trig_q <= selTrig ? wdat[1:0] : trig_q;
		end
	end

	// a config write blocks the poll of its own machine cycle; the set
	// wins over the end-of-cycle clear so a late write is not lost
	always_ff @(posedge clk) begin
		if (rst) begin
			cfgSeen_q <= 1'b0;
		end else begin
			cfgSeen_q <= cfgWr | (cfgSeen_q & ~pollEdge);
		end
	end

	// request flags and the pin history behind edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			flag_q <= `RST_BYTE;
			pinPrev_q <= `RST_PINS;
			ovfPend_q <= 2'h0;
		end else begin
			flag_q <= flag_d;
			if (samplePins) begin
				pinPrev_q <= pinSync;
			end
			// timer pulses wait for the next phase three sample
			ovfPend_q <= samplePins ? 2'h0 :
				ovfPend_q | {timer1OverflowSet, timer0OverflowSet};
		end
	end

	// snapshot at the start of each cycle: flags set at phase three are
	// seen only one machine cycle later, and nothing is kept over
	always_ff @(posedge clk) begin
		if (rst) begin
			snap_q <= '0;
		end else if (pollStart) begin
			snap_q <= srcFlag & srcEn;
		end
	end

	// call launch; the core pushes the PC only, as for a long call
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= CALL_IDLE;
			cnt_q <= '0;
			callBusy <= 1'b0;
			vecCall <= 1'b0;
			vecAddr <= 16'h0000;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			callBusy <= state_d == CALL_RUN;
			vecCall <= fire;
			if (fire) begin
				vecAddr <= vector_of(pickBus.winIdx);
			end
		end
	end

	// in-service bits; a plain return never reaches exitNow
	always_ff @(posedge clk) begin
		if (rst) begin
			inSvcHi <= 1'b0;
			inSvcLo <= 1'b0;
		end else if (fire) begin
			inSvcHi <= inSvcHi | pickBus.winHi;
			inSvcLo <= inSvcLo | ~pickBus.winHi;
		end else if (exitNow) begin
			inSvcHi <= 1'b0;
			inSvcLo <= inSvcHi & inSvcLo;
		end
	end

	property p_call_last;
		@(posedge clk) disable iff (rst)
		vecCall |-> $past(instrLast) && $past(phase) == `PHASE_LAST;
	endproperty
	a_call_last: assert property (p_call_last)
		else $error("call outside final machine cycle");

	property p_no_preempt;
		@(posedge clk) disable iff (rst)
		$rose(inSvcLo) |-> !$past(inSvcHi);
	endproperty
	a_no_preempt: assert property (p_no_preempt)
		else $error("low routine entered over high one");

	property p_suppress;
		@(posedge clk) disable iff (rst)
		vecCall |-> !$past(cfgSeen_q) && !$past(isrExitInstr)
			&& !$past(coreCfgWrite);
	endproperty
	a_suppress: assert property (p_suppress)
		else $error("call during blocked instruction");

	property p_call_len;
		@(posedge clk) disable iff (rst)
		$rose(callBusy) |-> vecCall ##15 callBusy ##1 !callBusy;
	endproperty
	a_call_len: assert property (p_call_len)
		else $error("call length is not four machine cycles");

	property p_tmr0_clear;
		@(posedge clk) disable iff (rst)
		vecCall && vecAddr == `VEC_TMR0 |->
			!flag_q[`FLAG_TMR0] || $past(flagWr);
	endproperty
	a_tmr0_clear: assert property (p_tmr0_clear)
		else $error("timer 0 flag not cleared on vectoring");

	property p_level_keep;
		@(posedge clk) disable iff (rst)
		vecCall && vecAddr == `VEC_EXT0 && !trig_q[0] |->
			flag_q[0] == $past(flag_q[0]) || $past(flagWr);
	endproperty
	a_level_keep: assert property (p_level_keep)
		else $error("level mode flag cleared by vectoring");

	property p_exit_hi;
		@(posedge clk) disable iff (rst)
		exitNow && inSvcHi |=> !inSvcHi && inSvcLo == $past(inSvcLo);
	endproperty
	a_exit_hi: assert property (p_exit_hi)
		else $error("return did not clear the high level");

	property p_vec_align;
		@(posedge clk) disable iff (rst)
		vecCall |-> vecAddr[2:0] == 3'h3 && vecAddr[15:7] == 9'h000;
	endproperty
	a_vec_align: assert property (p_vec_align)
		else $error("vector address off the table");

endmodule : two_level_priority_interrupt_unit

// File: sim/core_model.sv
`timescale 1ns/10ps

// stands in for the core sequencer: final-cycle flag, call push, return pop
module core_model (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset
	input wire logic vecCall, // start of hardware call
	input wire logic [15:0] vecAddr, // entry address
	input wire logic callBusy, // call in progress
	input wire logic lastEn, // every machine cycle ends an instruction
	input wire logic cfgWr, // instruction writes enable or priority
	input wire logic doExit, // one clock: run an interrupt return
	input wire logic doRet, // one clock: run a plain return
	output logic instrLast, // final machine cycle
	output logic coreCfgWrite, // configuration write under way
	output logic isrExitInstr // interrupt return under way
);
	logic [15:0] stack_q [0:7];
	logic [2:0] sp_q;
	logic [15:0] pc_q;
	logic [2:0] retCnt_q;
	logic plain_q;

	// a return lasts one machine cycle, so it meets exactly one poll
	always_ff @(posedge clk) begin
		if (rst) begin
			retCnt_q <= 3'h0;
			plain_q <= 1'b0;
		end else if (retCnt_q != 3'h0) begin
			retCnt_q <= retCnt_q - 3'h1;
		end else if (doExit || doRet) begin
			retCnt_q <= 3'h4;
			plain_q <= doRet;
		end
	end

	// push on the call, pop when either return ends
	always_ff @(posedge clk) begin
		if (rst) begin
			sp_q <= 3'h0;
			pc_q <= 16'h0000;
		end else if (vecCall) begin
			stack_q[sp_q] <= pc_q;
			sp_q <= sp_q + 3'h1;
			pc_q <= vecAddr;
		end else if (retCnt_q == 3'h1) begin
			sp_q <= sp_q - 3'h1;
			pc_q <= stack_q[sp_q - 3'h1];
		end else if (!callBusy) begin
			pc_q <= pc_q + 16'h0001;
		end
	end

	// no instruction ends while the call itself runs
	assign instrLast = (lastEn && !callBusy) || retCnt_q != 3'h0;
	assign isrExitInstr = retCnt_q != 3'h0 && !plain_q;
	assign coreCfgWrite = cfgWr;
endmodule : core_model

// File: sim/two_level_priority_interrupt_unit_tb.sv
`timescale 1ns/10ps
`include "irq_consts.svh"

module two_level_priority_interrupt_unit_tb;
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h0, rdat, got;
	logic [5:0] pinN = 6'h3F;
	logic t0Set = 0, t1Set = 0, t2Ovf = 0, t2Ext = 0, u0Rx = 0, u0Tx = 0;
	logic u1Rx = 0, u1Tx = 0, wdog = 0, pfail = 0;
	logic lastEn = 1, cfgWr = 0, doExit = 0, doRet = 0;
	logic instrLast, cfgWrite, isrExit, vecCall, callBusy, svcHi, svcLo;
	logic [15:0] vecAddr;
	logic [15:0] vecTab [12] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B,
		16'h0023, 16'h002B, 16'h003B, 16'h0043, 16'h004B, 16'h0053,
		16'h005B, 16'h0063};
	int fails = 0, nTests = 0;

	// clock at 20 MHz
	always #25 clk = ~clk;

	two_level_priority_interrupt_unit u_dut (.clk(clk), .rst(rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
		.extIrqPinN(pinN), .timer0OverflowSet(t0Set),
		.timer1OverflowSet(t1Set), .timer2OverflowFlag(t2Ovf),
		.timer2ExternalFlag(t2Ext), .uart0ReceiveDone(u0Rx),
		.uart0TransmitDone(u0Tx), .uart1ReceiveDone(u1Rx),
		.uart1TransmitDone(u1Tx), .wdogTimeoutFlag(wdog),
		.powerFailFlag(pfail), .instrLast(instrLast),
		.coreCfgWrite(cfgWrite), .isrExitInstr(isrExit), .vecCall(vecCall),
		.vecAddr(vecAddr), .callBusy(callBusy), .inSvcHi(svcHi),
		.inSvcLo(svcLo));

	core_model u_core (.clk(clk), .rst(rst), .vecCall(vecCall),
		.vecAddr(vecAddr), .callBusy(callBusy), .lastEn(lastEn),
		.cfgWr(cfgWr), .doExit(doExit), .doRet(doRet), .instrLast(instrLast),
		.coreCfgWrite(cfgWrite), .isrExitInstr(isrExit));

	task chk(input string name, input logic [31:0] exp, input logic [31:0] act);
		nTests++;
		if (act !== exp) begin
			fails++;
			$display("mismatch %s expected %0h seen %0h", name, exp, act);
		end
	endtask : chk

	// classic single cycle; ack and read data are taken at the same edge
	task wbXfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		wdat <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		chk("busAck", 32'h1, 32'(ack));
		got = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wbXfer

	// sources in tie order, pins are active low
	task setSrc(input int i, input logic v);
		@(posedge clk);
		case (i)
			0, 2: pinN[i / 2] <= !v;
			7, 8, 9, 10: pinN[i - 5] <= !v;
			1: t0Set <= v;
			3: t1Set <= v;
			4: u0Rx <= v;
			5: t2Ext <= v;
			6: u1Tx <= v;
			default: wdog <= v;
		endcase
	endtask : setSrc

	task waitCall(input string name, input logic [15:0] exp, input logic full);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (vecCall !== 1'b1 && n < 32);
		chk({name, "Call"}, 32'h1, 32'(vecCall));
		chk({name, "Vec"}, {16'h0, exp}, {16'h0, vecAddr});
		if (full) begin
			n = 0;
			do begin
				@(posedge clk);
				#1;
				n++;
			end while (callBusy === 1'b1 && n < 40);
			chk("busyLen", 32'h10, 32'(n));
			chk("pcLoad", {16'h0, exp}, {16'h0, u_core.pc_q});
		end
	endtask : waitCall

	task quiet(input string name, input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge clk);
			#1;
			// an unknown call strobe counts as a call
			if (vecCall !== 1'b0) begin
				seen = 1'b1;
			end
		end
		chk(name, 32'h0, 32'(seen));
	endtask : quiet

	// return window spans one machine cycle, then the effect has landed
	task ret(input logic isr);
		@(posedge clk);
		if (isr) doExit <= 1'b1;
		else doRet <= 1'b1;
		@(posedge clk);
		doExit <= 1'b0;
		doRet <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
	endtask : ret

	task endTest(input string name);
		$display("test %s done", name);
	endtask : endTest

	task results;
		$display("checks %0d mismatches %0d", nTests, fails);
		if (fails == 0 && nTests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	// hang guard, far beyond the thousand or so cycles the tests need
	initial begin
		#(50 * 10000);
		fails++;
		results();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 8; a++) begin
			wbXfer(1'b0, 8'(a * 4), 8'h00);
			chk("regReset", 32'h0, got);
		end
		// a write without the low byte lane must leave the register alone
		sel <= 4'hE;
		wbXfer(1'b1, 8'h10, 8'h03);
		sel <= 4'hF;
		wbXfer(1'b0, 8'h10, 8'h00);
		chk("selLow", 32'h0, got);
		wbXfer(1'b1, 8'h00, 8'hFF);
		wbXfer(1'b1, 8'h08, 8'h1F);
		setSrc(0, 1'b1);
		waitCall("level", 16'h0003, 1'b1);
		wbXfer(1'b0, 8'h14, 8'h00);
		chk("levelFlag", 32'h1, got);
		setSrc(0, 1'b0);
		repeat (8) @(posedge clk);
		ret(1'b1);
		wbXfer(1'b1, 8'h10, 8'h03);
		endTest("reset and level");
		// every source but power fail alone, each with its own flag side effect
		for (int i = 0; i < 12; i++) begin
			fork
				begin
					setSrc(i, 1'b1);
					if (i inside {0, 2, [7:10]}) repeat (8) @(posedge clk);
					if (i inside {[0:3], [7:10]}) setSrc(i, 1'b0);
				end
				waitCall("src", vecTab[i], 1'b1);
			join
			wbXfer(1'b0, 8'h14, 8'h00);
			chk("flags", (i >= 7 && i <= 10) ? 32'h1 << (i - 5) : 32'h0,
				got);
			chk("svcLo", 32'h1, 32'(svcLo));
			setSrc(i, 1'b0);
			wbXfer(1'b1, 8'h14, 8'h00);
			ret(1'b1);
			chk("svcEnd", 32'h0, 32'(svcLo));
		end
		endTest("vectors");
		@(posedge clk);
		lastEn <= 1'b0;
		u0Tx <= 1'b1;
		wdog <= 1'b1;
		quiet("notLast", 16);
		@(posedge clk);
		lastEn <= 1'b1;
		waitCall("tie", 16'h0023, 1'b1);
		quiet("sameLevel", 16);
		@(posedge clk);
		u0Tx <= 1'b0;
		ret(1'b1);
		waitCall("next", 16'h0063, 1'b1);
		@(posedge clk);
		wdog <= 1'b0;
		ret(1'b1);
		endTest("tie");
		wbXfer(1'b1, 8'h0C, 8'h10);
		@(posedge clk);
		u0Rx <= 1'b1;
		waitCall("lowFirst", 16'h0023, 1'b1);
		@(posedge clk);
		wdog <= 1'b1;
		waitCall("preempt", 16'h0063, 1'b1);
		chk("svcHi", 32'h1, 32'(svcHi));
		@(posedge clk);
		t2Ovf <= 1'b1;
		quiet("lowOverHigh", 16);
		@(posedge clk);
		wdog <= 1'b0;
		ret(1'b1);
		chk("hiCleared", 32'h0, 32'(svcHi));
		chk("loKept", 32'h1, 32'(svcLo));
		ret(1'b0);
		chk("plainRet", 32'h1, 32'(svcLo));
		@(posedge clk);
		u0Rx <= 1'b0;
		t2Ovf <= 1'b0;
		ret(1'b1);
		endTest("preempt");
		wbXfer(1'b1, 8'h00, 8'h7F);
		@(posedge clk);
		u0Rx <= 1'b1;
		quiet("gateOff", 16);
		@(posedge clk);
		pfail <= 1'b1;
		waitCall("powerFail", `VEC_PFAIL, 1'b1);
		@(posedge clk);
		pfail <= 1'b0;
		ret(1'b1);
		@(posedge clk);
		u0Rx <= 1'b0;
		wbXfer(1'b1, 8'h00, 8'hFF);
		quiet("notLatched", 16);
		endTest("gate");
		@(posedge clk);
		cfgWr <= 1'b1;
		u1Tx <= 1'b1;
		quiet("cfgWrite", 16);
		@(posedge clk);
		cfgWr <= 1'b0;
		waitCall("cfgDone", 16'h003B, 1'b0);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("rstBusy", 32'h0, 32'(callBusy));
		chk("rstSvc", 32'h0, {30'h0, svcHi, svcLo});
		quiet("afterRst", 16);
		@(posedge clk);
		u1Tx <= 1'b0;
		endTest("reset mid call");
		results();
	end
endmodule : two_level_priority_interrupt_unit_tb
